// >>> fsc_pkg.sv
/*
 * Shared constants, types and timing for the host controller of the
 * flash plus SRAM combination memory.
 * Assumes a 200 MHz system clock; all pin timings are derived from it.
 */
package fsc_pkg;

    localparam int CLK_NS = 5;

    // pin timing in ns, least times rounded up to whole cycles
    localparam int T_AS_NS = 20;
    localparam int T_WP_NS = 100;
    localparam int T_ACC_NS = 300;
    localparam int T_REC_NS = 30;
    localparam int SYNC_LAT = 3;
    localparam logic [7:0] C_AS = 8'((T_AS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_WP = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] C_ACC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
    localparam logic [7:0] C_REC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);

    // longest byte program time, rounded down
    localparam int PROG_MAX_NS = 20000;
    localparam logic [11:0] C_PROG = 12'(PROG_MAX_NS / CLK_NS);

    localparam logic [18:0] SRAM_LIMIT = 19'h20000;
    localparam logic [18:0] UNLOCK_A0 = 19'h05555;
    localparam logic [18:0] UNLOCK_A1 = 19'h02AAA;
    localparam logic [7:0] UNLOCK_D0 = 8'hAA;
    localparam logic [7:0] UNLOCK_D1 = 8'h55;
    localparam logic [7:0] PROG_SETUP = 8'hA0;
    localparam logic [1:0] STEP_LAST = 2'h3;

    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [11:0] POLL_ONE = 12'h001;

    typedef enum logic [1:0] {
        OP_SRAM_RD,
        OP_SRAM_WR,
        OP_FLASH_RD,
        OP_FLASH_PROG
    } fsc_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } fsc_st_t;

    typedef struct packed {
        fsc_op_t op;
        logic [18:0] addr;
        logic [7:0] wdata;
    } fsc_cmd_t;

    typedef struct packed {
        logic [18:0] a;
        logic [7:0] dq_o;
        logic dq_oe_n;
        logic we_n;
        logic oe_n;
        logic flash_bank_select_n;
        logic sram_bank_select_n;
    } fsc_pins_t;

    typedef struct packed {
        fsc_st_t st;
        fsc_op_t op;
        logic [1:0] step;
        logic [7:0] cnt;
        logic [11:0] poll_cnt;
        logic busy;
        logic fail;
        logic poll;
        logic [18:0] addr;
        logic [7:0] wdata;
        logic [18:0] paddr;
        logic [7:0] pdata;
        fsc_pins_t pins;
        logic rdy;
        logic rsp_v;
        logic rsp_e;
        logic [7:0] rsp_d;
    } fsc_state_t;

endpackage

// >>> fsc_dq_sync.sv
/*
 * Three-stage synchroniser for the returned data lines.
 * Assumes the data pins change asynchronously to the system clock.
 */
`timescale 1ns/1ps
module fsc_dq_sync
    import fsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] d,
    output logic [7:0] q
);
    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] q;
    } fsc_sync_t;

    fsc_sync_t sync_r;
    fsc_sync_t sync_nxt;

    // a bit moves only once stages two and three agree
    always_comb begin
        sync_nxt = sync_r;
        sync_nxt.s1 = d;
        sync_nxt.s2 = sync_r.s1;
        sync_nxt.s3 = sync_r.s2;
        sync_nxt.q = (sync_r.s2 & ~(sync_r.s2 ^ sync_r.s3))
                   | (sync_r.q & (sync_r.s2 ^ sync_r.s3));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_r <= '0;
        end else if (ce) begin
            sync_r <= sync_nxt;
        end
    end

    assign q = sync_r.q;
endmodule

// >>> fsc_host.sv
/*
 * Host controller driving the asynchronous pins of a combined
 * 512K x8 flash and 128K x8 SRAM memory: SRAM read/write, flash read,
 * and flash byte program with completion polling.
 * Assumes the testbench resolves the data bus from MEM_DQ_OE_N and
 * that the memory is the larger SRAM variant.
 */
// Functional notes
// - SRAM write while write strobe and SRAM select both low
// - output enable held at a firm level during SRAM writes
// - command load: strobe low, flash select low, output enable high
// - program: two unlock writes and a setup write, then address and data write
// - location must be erased before it is programmed
// - host avoids selecting both banks at once
// - shared pin variant: one pin is SRAM select and output enable
`timescale 1ns/1ps
module fsc_host
    import fsc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic CMD_VALID,
    input fsc_cmd_t CMD,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic RSP_ERR,
    output logic [7:0] RSP_RDATA,
    output logic FLASH_BUSY,
    output logic FLASH_FAIL,
    output logic [18:0] MEM_ADDR,
    output logic [7:0] MEM_DQ_OUT,
    output logic MEM_DQ_OE_N,
    input wire logic [7:0] MEM_DQ_IN,
    output logic MEM_WE_N,
    output logic MEM_OE_N,
    output logic MEM_FLASH_BANK_SELECT_N,
    output logic MEM_SRAM_BANK_SELECT_N
);
    fsc_state_t st_r;
    fsc_state_t st_nxt;
    logic [7:0] dq_sync;

    fsc_dq_sync u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CE),
        .d(MEM_DQ_IN),
        .q(dq_sync)
    );

    function automatic logic is_flash(input fsc_op_t op);
        return op == OP_FLASH_RD || op == OP_FLASH_PROG;
    endfunction

    function automatic logic is_write(input fsc_op_t op);
        return op == OP_SRAM_WR || op == OP_FLASH_PROG;
    endfunction

    // pins idle: both banks deselected, bus released
    function automatic fsc_pins_t pins_idle(input fsc_pins_t p);
        fsc_pins_t t;
        t = p;
        t.dq_oe_n = 1'b1;
        t.we_n = 1'b1;
        t.oe_n = 1'b1;
        t.flash_bank_select_n = 1'b1;
        t.sram_bank_select_n = 1'b1;
        return t;
    endfunction

    // start a bus cycle: address and one bank select, strobes still high
    function automatic fsc_state_t launch(input fsc_state_t s);
        fsc_state_t t;
        logic [18:0] a;
        logic [7:0] d;
        t = s;
        a = s.addr;
        d = s.wdata;
        if (s.op == OP_FLASH_PROG) begin
            case (s.step)
                2'h0: begin
                    a = UNLOCK_A0;
                    d = UNLOCK_D0;
                end
                2'h1: begin
                    a = UNLOCK_A1;
                    d = UNLOCK_D1;
                end
                2'h2: begin
                    a = UNLOCK_A0;
                    d = PROG_SETUP;
                end
                default: begin
                    a = s.addr;
                    d = s.wdata;
                end
            endcase
        end
        t.st = ST_SETUP;
        t.cnt = C_AS;
        t.rdy = 1'b0;
        t.pins.a = a;
        t.pins.dq_o = d;
        t.pins.dq_oe_n = !is_write(s.op);
        t.pins.we_n = 1'b1;
        t.pins.oe_n = 1'b1;
        // exactly one bank selected per cycle
        t.pins.flash_bank_select_n = !is_flash(s.op);
        t.pins.sram_bank_select_n = is_flash(s.op);
        return t;
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp_v = 1'b0;
        // program watchdog counts while the device works alone
        if (st_r.busy && st_r.poll_cnt != C_PROG) begin
            st_nxt.poll_cnt = st_r.poll_cnt + POLL_ONE;
        end
        case (st_r.st)
            ST_IDLE: begin
                st_nxt.rdy = 1'b1;
                st_nxt.pins = pins_idle(st_r.pins);
                if (CMD_VALID && st_r.rdy) begin
                    st_nxt.op = CMD.op;
                    st_nxt.addr = CMD.addr;
                    st_nxt.wdata = CMD.wdata;
                    st_nxt.step = 2'h0;
                    st_nxt.poll = 1'b0;
                    if ((is_flash(CMD.op) && st_r.busy)
                        || (!is_flash(CMD.op) && CMD.addr >= SRAM_LIMIT)) begin
                        st_nxt.rsp_v = 1'b1;
                        st_nxt.rsp_e = 1'b1;
                        st_nxt.rsp_d = 8'h00;
                    end else begin
                        st_nxt = launch(st_nxt);
                    end
                end else if (st_r.busy) begin
                    // background status read; a waiting command goes first
                    st_nxt.op = OP_FLASH_RD;
                    st_nxt.addr = st_r.paddr;
                    st_nxt.poll = 1'b1;
                    st_nxt = launch(st_nxt);
                end
            end
            ST_SETUP: begin
                if (st_r.cnt == CNT_ONE || st_r.cnt == CNT_ZERO) begin
                    st_nxt.st = ST_STROBE;
                    if (is_write(st_r.op)) begin
                        // strobe falls after select: later falling edge takes address
                        st_nxt.cnt = C_WP;
                        st_nxt.pins.we_n = 1'b0;
                    end else begin
                        st_nxt.cnt = C_ACC;
                        st_nxt.pins.oe_n = 1'b0;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt - CNT_ONE;
                end
            end
            ST_STROBE: begin
                if (st_r.cnt == CNT_ONE || st_r.cnt == CNT_ZERO) begin
                    st_nxt.st = ST_HOLD;
                    st_nxt.cnt = C_REC;
                    if (!is_write(st_r.op)) begin
                        // sample includes the synchroniser latency
                        st_nxt.rsp_d = dq_sync;
                    end
                    // both rise together; data stays driven through the hold
                    st_nxt.pins.we_n = 1'b1;
                    st_nxt.pins.oe_n = 1'b1;
                    st_nxt.pins.flash_bank_select_n = 1'b1;
                    st_nxt.pins.sram_bank_select_n = 1'b1;
                end else begin
                    st_nxt.cnt = st_r.cnt - CNT_ONE;
                end
            end
            ST_HOLD: begin
                if (st_r.cnt == CNT_ONE || st_r.cnt == CNT_ZERO) begin
                    st_nxt.pins = pins_idle(st_r.pins);
                    st_nxt.st = ST_IDLE;
                    st_nxt.rdy = 1'b1;
                    if (st_r.op == OP_FLASH_PROG && st_r.step != STEP_LAST) begin
                        st_nxt.step = st_r.step + 2'h1;
                        st_nxt = launch(st_nxt);
                    end else if (st_r.op == OP_FLASH_PROG) begin
                        // device now runs alone; host only polls
                        st_nxt.busy = 1'b1;
                        st_nxt.fail = 1'b0;
                        st_nxt.poll_cnt = 12'h000;
                        st_nxt.paddr = st_r.addr;
                        st_nxt.pdata = st_r.wdata;
                        st_nxt.rsp_v = 1'b1;
                        st_nxt.rsp_e = 1'b0;
                    end else if (st_r.poll) begin
                        // true data on the top bit ends the program
                        if (st_r.rsp_d[7] == st_r.pdata[7]) begin
                            st_nxt.busy = 1'b0;
                        // an unerased cell whose top bit is low never shows a high data bit there, so it ends here as fail
                        end else if (st_r.poll_cnt == C_PROG) begin
                            st_nxt.busy = 1'b0;
                            st_nxt.fail = 1'b1;
                        end
                    end else begin
                        st_nxt.rsp_v = 1'b1;
                        st_nxt.rsp_e = 1'b0;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt - CNT_ONE;
                end
            end
            default: begin
                st_nxt.st = ST_IDLE;
                st_nxt.pins = pins_idle(st_r.pins);
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_r <= '0;
            st_r.st <= ST_IDLE;
            st_r.pins.dq_oe_n <= 1'b1;
            st_r.pins.we_n <= 1'b1;
            st_r.pins.oe_n <= 1'b1;
            st_r.pins.flash_bank_select_n <= 1'b1;
            st_r.pins.sram_bank_select_n <= 1'b1;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    assign CMD_READY = st_r.rdy;
    assign RSP_VALID = st_r.rsp_v;
    assign RSP_ERR = st_r.rsp_e;
    assign RSP_RDATA = st_r.rsp_d;
    assign FLASH_BUSY = st_r.busy;
    assign FLASH_FAIL = st_r.fail;
    assign MEM_ADDR = st_r.pins.a;
    assign MEM_DQ_OUT = st_r.pins.dq_o;
    assign MEM_DQ_OE_N = st_r.pins.dq_oe_n;
    assign MEM_WE_N = st_r.pins.we_n;
    assign MEM_OE_N = st_r.pins.oe_n;
    assign MEM_FLASH_BANK_SELECT_N = st_r.pins.flash_bank_select_n;
    assign MEM_SRAM_BANK_SELECT_N = st_r.pins.sram_bank_select_n;
endmodule

// >>> fsc_host_assertions.sv
/* Concurrent checks on the pins and command port of fsc_host.
   Assumes CE stays high while pulse and busy spans are counted. */
`timescale 1ns/1ps
module fsc_host_assertions
    import fsc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic CMD_VALID,
    input fsc_cmd_t CMD,
    input wire logic CMD_READY,
    input wire logic RSP_VALID,
    input wire logic RSP_ERR,
    input wire logic FLASH_BUSY,
    input wire logic FLASH_FAIL,
    input wire logic [18:0] MEM_ADDR,
    input wire logic [7:0] MEM_DQ_OUT,
    input wire logic MEM_DQ_OE_N,
    input wire logic MEM_WE_N,
    input wire logic MEM_OE_N,
    input wire logic MEM_FLASH_BANK_SELECT_N,
    input wire logic MEM_SRAM_BANK_SELECT_N
);
    logic [7:0] wp_cnt;
    logic [12:0] busy_cnt;
    logic take;
    assign take = CE && CMD_VALID && CMD_READY;
    always_ff @(posedge SYS_CLK) begin
        if (RST || MEM_WE_N) wp_cnt <= CNT_ZERO;
        else if (CE) wp_cnt <= wp_cnt + CNT_ONE;
        if (RST || !FLASH_BUSY) busy_cnt <= 13'h0000;
        else if (CE) busy_cnt <= busy_cnt + 13'h0001;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_banks_never_both:
        assert property (MEM_FLASH_BANK_SELECT_N || MEM_SRAM_BANK_SELECT_N)
        else $error("both bank selects low");
    a_idle_standby:
        assert property (CMD_READY |-> MEM_FLASH_BANK_SELECT_N && MEM_SRAM_BANK_SELECT_N
            && MEM_WE_N && MEM_OE_N) else $error("pins not idle while ready");
    a_read_bus_released:
        assert property (!MEM_OE_N |-> MEM_DQ_OE_N) else $error("host drives bus in read");
    a_strobe_oe_high:
        assert property (!MEM_WE_N |-> MEM_OE_N && !MEM_DQ_OE_N)
        else $error("strobe low without firm output enable or data");
    a_write_held_stable:
        assert property (!MEM_WE_N |-> $stable(MEM_ADDR) && $stable(MEM_DQ_OUT))
        else $error("address or data moved under strobe");
    a_strobe_pulse_width:
        assert property ($rose(MEM_WE_N) |-> wp_cnt == C_WP) else $error("strobe width wrong");
    a_refuse_high_sram:
        assert property (take && CMD.op inside {OP_SRAM_RD, OP_SRAM_WR}
            && CMD.addr >= SRAM_LIMIT |=> RSP_VALID && RSP_ERR)
        else $error("high sram address not refused");
    a_busy_flash_refused:
        assert property (take && FLASH_BUSY && CMD.op inside {OP_FLASH_RD, OP_FLASH_PROG}
            |=> RSP_VALID && RSP_ERR) else $error("flash access taken while busy");
    a_busy_span_bound:
        assert property (busy_cnt <= {1'b0, C_PROG} + 13'h00C8) else $error("busy too long");
    a_fail_after_limit:
        assert property ($rose(FLASH_FAIL) |-> busy_cnt >= {1'b0, C_PROG})
        else $error("fail raised early");
    cover property (FLASH_BUSY && !MEM_WE_N && !MEM_SRAM_BANK_SELECT_N);
    cover property ($rose(FLASH_FAIL));
    cover property (RSP_VALID && RSP_ERR);
endmodule

bind fsc_host fsc_host_assertions fsc_host_assertions_inst (.SYS_CLK, .RST, .CE, .CMD_VALID,
    .CMD, .CMD_READY, .RSP_VALID, .RSP_ERR, .FLASH_BUSY, .FLASH_FAIL, .MEM_ADDR, .MEM_DQ_OUT,
    .MEM_DQ_OE_N, .MEM_WE_N, .MEM_OE_N, .MEM_FLASH_BANK_SELECT_N, .MEM_SRAM_BANK_SELECT_N);

// >>> fsc_mem_model.sv
/* Behavioural model of the combined flash and SRAM memory.
   Assumes the bench resolves the data bus; the bench may lengthen prog_ns. */
`timescale 1ns/1ps
module fsc_mem_model
    import fsc_pkg::*;
(
    input wire logic [18:0] a,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic fsel_n,
    input wire logic ssel_n,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o
);
    logic [7:0] sram [0:131071];
    logic [7:0] flash [0:524287];
    int prog_ns = 6000;
    logic busy = 0, tog = 0, wr_on = 0, wr_fl = 0;
    logic [1:0] step = 2'h0;
    logic [18:0] la;
    logic [7:0] pd, last = 8'h00;
    logic f_rd, s_rd;
    function automatic logic [7:0] fget(input logic [18:0] x);
        return flash[x];
    endfunction
    // array starts erased
    initial begin
        for (int i = 0; i < 524288; i++) begin
            flash[i] = 8'hFF;
        end
    end
    task automatic cmd(input logic [7:0] d);
        if (step == STEP_LAST) begin
            pd = d;
            flash[la] = fget(la) & d;
            busy = 1;
            step = 2'h0;
        end else if (la == (step[0] ? UNLOCK_A1 : UNLOCK_A0)
            && d == (step == 2'h0 ? UNLOCK_D0 : step == 2'h1 ? UNLOCK_D1 : PROG_SETUP)) begin
            step = step + 2'h1;
        end else step = 2'h0;
    endtask
    assign f_rd = !fsel_n && !oe_n && we_n;
    assign s_rd = fsel_n && !ssel_n && !oe_n && we_n && a < SRAM_LIMIT;
    always @* begin
        if (f_rd) dq_o = busy ? {~pd[7], tog, 6'h00} : fget(a);
        else if (s_rd) dq_o = sram[a[16:0]];
        else dq_o = ~last;
    end
    // released bus shows the inverse so a stale byte never passes
    always @(dq_o) if (f_rd || s_rd) last = dq_o;
    always @(negedge oe_n) if (!fsel_n && busy) tog = ~tog;
    always @(negedge we_n or negedge fsel_n or negedge ssel_n) begin
        if (!we_n && (fsel_n ? !ssel_n : oe_n)) begin
            wr_on = 1;
            wr_fl = !fsel_n;
            la = a;
        end
    end
    always @(posedge we_n or posedge fsel_n or posedge ssel_n) begin
        if (wr_on) begin
            wr_on = 0;
            if (!wr_fl && la < SRAM_LIMIT) sram[la[16:0]] = dq_i;
            else if (wr_fl && !busy) cmd(dq_i);
        end
    end
    always @(posedge busy) begin
        #(prog_ns);
        busy = 0;
    end
endmodule

// >>> fsc_host_tb.sv
/* Self-checking bench for fsc_host against the memory model.
   Assumes CE stays high; the model's program time is lengthened only for the fail scenario. */
`timescale 1ns/1ps
module fsc_host_tb
    import fsc_pkg::*;
;
    logic sys_clk = 0, rst = 1, ce = 1, cmd_valid = 0, r_e;
    fsc_cmd_t cmd = '0;
    logic cmd_ready, rsp_valid, rsp_err, flash_busy, flash_fail;
    logic dq_oe_n, we_n, oe_n, fsel_n, ssel_n;
    logic [7:0] rsp_rdata, dq_out, dq_dev, dq_bus, r_d;
    logic [18:0] mem_addr;
    int failures = 0, checked = 0;
    always #2.5 sys_clk = ~sys_clk;
    assign dq_bus = dq_oe_n ? dq_dev : dq_out;
    fsc_host fsc_host_inst (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .CMD_VALID(cmd_valid),
        .CMD(cmd), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err),
        .RSP_RDATA(rsp_rdata), .FLASH_BUSY(flash_busy), .FLASH_FAIL(flash_fail),
        .MEM_ADDR(mem_addr), .MEM_DQ_OUT(dq_out), .MEM_DQ_OE_N(dq_oe_n), .MEM_DQ_IN(dq_bus),
        .MEM_WE_N(we_n), .MEM_OE_N(oe_n), .MEM_FLASH_BANK_SELECT_N(fsel_n),
        .MEM_SRAM_BANK_SELECT_N(ssel_n));
    fsc_mem_model fsc_mem_model_inst (.a(mem_addr), .we_n(we_n), .oe_n(oe_n), .fsel_n(fsel_n),
        .ssel_n(ssel_n), .dq_i(dq_bus), .dq_o(dq_dev));
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask
    task automatic run(input fsc_op_t op, input logic [18:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cmd_valid = 1;
        cmd = '{op, a, d};
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        @(posedge sys_clk);
        #1;
        cmd_valid = 0;
        while (rsp_valid !== 1'b1 && n < 4000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk1("answer", 1'b1, rsp_valid);
        r_e = rsp_err;
        r_d = rsp_rdata;
        // an edge passes so the next request never lands on the same step as this release
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (flash_busy !== 1'b0 && n < 5000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    task automatic t_sram();
        run(OP_SRAM_WR, 19'h1FFFF, 8'h5A);
        chk8("pin write", 8'h5A, fsc_mem_model_inst.sram[17'h1FFFF]);
        run(OP_SRAM_WR, 19'h00000, 8'hA5);
        run(OP_SRAM_RD, 19'h1FFFF, 8'h00);
        chk8("sram top", 8'h5A, r_d);
        run(OP_SRAM_RD, 19'h00000, 8'h00);
        chk8("sram low", 8'hA5, r_d);
        run(OP_SRAM_WR, SRAM_LIMIT, 8'h11);
        chk1("sram limit err", 1'b1, r_e);
    endtask
    task automatic t_prog();
        run(OP_FLASH_PROG, 19'h12345, 8'h3C);
        chk1("prog err", 1'b0, r_e);
        chk1("busy set", 1'b1, flash_busy);
        chk1("device started", 1'b1, fsc_mem_model_inst.busy);
        run(OP_SRAM_WR, 19'h00010, 8'hC3);
        run(OP_SRAM_RD, 19'h00010, 8'h00);
        chk8("sram in prog", 8'hC3, r_d);
        run(OP_FLASH_RD, 19'h12345, 8'h00);
        chk1("busy read err", 1'b1, r_e);
        run(OP_FLASH_PROG, 19'h00001, 8'h00);
        chk1("busy prog err", 1'b1, r_e);
        wait_idle();
        chk1("busy clear", 1'b0, flash_busy);
        chk1("fail clear", 1'b0, flash_fail);
        run(OP_FLASH_RD, 19'h12345, 8'h00);
        chk8("flash byte", 8'h3C, r_d);
    endtask
    task automatic t_fail();
        // the model now overruns its program time on purpose
        fsc_mem_model_inst.prog_ns = 30000;
        run(OP_FLASH_PROG, 19'h00100, 8'h0F);
        wait_idle();
        chk1("fail set", 1'b1, flash_fail);
        chk1("busy dropped", 1'b0, flash_busy);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 0;
        t_sram();
        t_prog();
        t_fail();
        wrap_up();
    end
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule
